/* design/card_bus_regs.vh */
// Constants for the card bus, idle insertion and arbitration block
`ifndef CARD_BUS_REGS_VH
`define CARD_BUS_REGS_VH
`define REG_CTRL_ONE      3'h0
`define REG_CTRL_TWO      3'h1
`define REG_IDLE          3'h2
`define REG_WAIT          3'h3
`define REG_TIMING        3'h4
`define REG_STATUS        3'h5
`define REG_ENDIAN        3'h6
`define AREA5             3'h5
`define AREA6             3'h6
`define AREA_NONE         3'h7
`define CARD_MEM_TOP      1'b0
`define IO_WIN_LO         4'hd
`define ST_IDLE           3'h0
`define ST_GAP            3'h1
`define ST_SETUP          3'h2
`define ST_STROBE         3'h3
`define ST_HOLD           3'h4
`define ST_RELEASED       3'h5
`define GAP_W             2
`endif

/* design/cycle_timer.v */
// Down counter that measures out one phase of a bus cycle
`timescale 1ns/1ps
module cycle_timer
#(
   parameter W = 4
)
(
   input  wire         clk,
   input  wire         rst_n,
   input  wire         load,
   input  wire [W-1:0] count,
   output wire         done
);
   reg [W-1:0] remain;
   always @(posedge clk)
   begin
      if (!rst_n)
         remain <= {W{1'b0}};
      else if (load)
         remain <= count;
      else if (remain != {W{1'b0}})
         remain <= remain - {{(W-1){1'b0}}, 1'b1};
   end
   assign done = (remain == {W{1'b0}}) && !load;
endmodule

/* design/pin_sync.v */
// Three-stage synchroniser; a change counts when stages two and three agree
`timescale 1ns/1ps
module pin_sync
#(
   parameter RST = 1'b1
)
(
   input  wire clk,
   input  wire rst_n,
   input  wire pin,
   output reg  level
);
   reg s1;
   reg s2;
   reg s3;
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         s1    <= RST;
         s2    <= RST;
         s3    <= RST;
         level <= RST;
      end
      else
      begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            level <= s3;
      end
   end
endmodule

/* design/card_bus_ctrl.v */
// Card area bus controller with idle insertion and bus arbitration
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "card_bus_regs.vh"
module card_bus_ctrl
#(
   parameter TW = 4
)
(
   input  wire        clk,
   input  wire        rst_n,
   input  wire [2:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_write,
   input  wire        reg_read,
   output reg  [31:0] reg_rdata,
   input  wire        req_valid,
   input  wire [28:0] req_addr,
   input  wire        req_write,
   input  wire        req_word,
   input  wire        req_fill,
   input  wire [2:0]  req_area,
   output reg         req_done,
   input  wire        wait_pin_n,
   input  wire        io_port_wide_sense_n,
   input  wire        bus_release_request_n,
   input  wire        refresh_pending,
   input  wire        refresh_start,
   input  wire [3:0]  irq_level,
   input  wire [3:0]  interrupt_mask_field,
   output reg         bus_grant_n,
   output reg         bus_reclaim_request_n,
   output reg  [25:0] bus_addr,
   output reg         card_enable_low_byte_n,
   output reg         card_enable_high_byte_n,
   output reg         read_strobe_n,
   output reg         write_strobe_pin_n,
   output reg         io_cycle,
   output reg         bus_width16,
   output reg         bus_busy
);
   // Software-visible control
   reg [31:0] bus_control_one;
   reg [31:0] bus_control_two;
   reg [31:0] idle_wait_control;
   reg [31:0] access_wait_control;
   reg [31:0] card_timing_control;
   reg        little_endian;
   // Cycle state
   reg [2:0]  state;
   reg [2:0]  prev_area;
   reg        prev_read;
   reg        prev_valid;
   reg [1:0]  empty_cnt;
   reg        arb_gap;
   reg        fill_active;
   reg        split_second;
   reg [2:0]  burst_left;
   reg [2:0]  cur_area;
   reg        cur_io;
   reg        cur_write;
   reg        timer_load;
   reg [TW-1:0] timer_count;
   wire       timer_done;
   wire       wait_n;
   wire       wide_sense_n;
   wire       release_req_n;
   cycle_timer #(.W(TW)) u_timer
   (
      .clk   (clk),
      .rst_n (rst_n),
      .load  (timer_load),
      .count (timer_count),
      .done  (timer_done)
   );
   pin_sync #(.RST(1'b1)) u_wait
   (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (wait_pin_n),
      .level (wait_n)
   );
   pin_sync #(.RST(1'b0)) u_wide
   (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (io_port_wide_sense_n),
      .level (wide_sense_n)
   );
   pin_sync #(.RST(1'b1)) u_bus_release_request
   (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (bus_release_request_n),
      .level (release_req_n)
   );
   // Field decode
   wire area5_card_select = bus_control_one[3];
   wire area6_card_select = bus_control_one[2];
   wire [1:0] area5_burst = {bus_control_one[7], bus_control_one[6]};
   wire [1:0] area6_burst = {bus_control_one[5], bus_control_one[4]};
   wire [1:0] area5_width = {bus_control_two[11], bus_control_two[10]};
   wire [1:0] area6_width = {bus_control_two[13], bus_control_two[12]};
   wire req_card = (req_area == `AREA5 && area5_card_select) ||
                   (req_area == `AREA6 && area6_card_select);
   wire req_low32 = (req_addr[25] == `CARD_MEM_TOP);
   wire req_io = (req_area == `AREA6) && area6_card_select &&
                 (req_addr[28:25] == `IO_WIN_LO);
   wire [1:0] req_width = (req_area == `AREA5) ? area5_width : area6_width;
   wire [1:0] req_burst = (req_area == `AREA5) ? area5_burst : area6_burst;
   wire [1:0] setup_cyc = (cur_area == `AREA5) ? card_timing_control[7:6]
                                               : card_timing_control[3:2];
   // Set-up of the incoming area; cur_area still names the last one
   wire [1:0] req_setup = (req_area == `AREA5) ? card_timing_control[7:6]
                                               : card_timing_control[3:2];
   wire [1:0] hold_cyc  = (cur_area == `AREA5) ? card_timing_control[5:4]
                                               : card_timing_control[1:0];
   wire [2:0] sw_wait   = (cur_area == `AREA5) ? access_wait_control[17:15]
                                               : access_wait_control[20:18];
   // Idle count of the previous area minus already empty cycles
   wire [1:0] prev_idle_field = idle_wait_control[{prev_area, 1'b0} +: 2];
   wire need_gap = prev_valid && !arb_gap &&
                   ((req_area != prev_area) || (prev_read && req_write));
   wire [1:0] gap_left = (prev_idle_field > empty_cnt) ?
                         (prev_idle_field - empty_cnt) : 2'h0;
   wire irq_qual = irq_level > interrupt_mask_field;
   wire release_ok = !release_req_n && !fill_active;
   // Narrow port split only in little endian on a 16-bit area 6
   wire do_split = cur_io && little_endian && bus_width16 && req_word &&
                   wide_sense_n && !split_second;
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         bus_control_one     <= 32'h00000000;
         bus_control_two     <= 32'h00000000;
         idle_wait_control   <= 32'h00000000;
         access_wait_control <= 32'h00000000;
         card_timing_control <= 32'h00000000;
         little_endian       <= 1'b0;
         reg_rdata           <= 32'h00000000;
      end
      else
      begin
         if (reg_write)
         begin
            case (reg_addr)
               `REG_CTRL_ONE: bus_control_one     <= reg_wdata;
               `REG_CTRL_TWO: bus_control_two     <= reg_wdata;
               `REG_IDLE:     idle_wait_control   <= reg_wdata;
               `REG_WAIT:     access_wait_control <= reg_wdata;
               `REG_TIMING:   card_timing_control <= reg_wdata;
               `REG_ENDIAN:   little_endian       <= reg_wdata[0];
               default:       little_endian       <= little_endian;
            endcase
         end
         if (reg_read)
         begin
            case (reg_addr)
               `REG_CTRL_ONE: reg_rdata <= bus_control_one;
               `REG_CTRL_TWO: reg_rdata <= bus_control_two;
               `REG_IDLE:     reg_rdata <= idle_wait_control;
               `REG_WAIT:     reg_rdata <= access_wait_control;
               `REG_TIMING:   reg_rdata <= card_timing_control;
               `REG_STATUS:   reg_rdata <= {25'h0000000, state, prev_area, ~bus_grant_n};
               `REG_ENDIAN:   reg_rdata <= {31'h00000000, little_endian};
               default:       reg_rdata <= 32'h00000000;
            endcase
         end
         else
            reg_rdata <= 32'h00000000;
      end
   end
   // Bus reclaim: refresh pending or qualifying interrupt
   always @(posedge clk)
   begin
      if (!rst_n)
         bus_reclaim_request_n <= 1'b1;
      else
         bus_reclaim_request_n <= !((refresh_pending && !refresh_start) ||
                                    irq_qual);
   end
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         state        <= `ST_IDLE;
         prev_area    <= `AREA_NONE;
         prev_read    <= 1'b0;
         prev_valid   <= 1'b0;
         empty_cnt    <= 2'h0;
         arb_gap      <= 1'b0;
         fill_active  <= 1'b0;
         split_second <= 1'b0;
         burst_left   <= 3'h0;
         cur_area     <= `AREA_NONE;
         cur_io       <= 1'b0;
         cur_write    <= 1'b0;
         timer_load   <= 1'b0;
         timer_count  <= {TW{1'b0}};
         req_done     <= 1'b0;
         bus_grant_n  <= 1'b1;
         bus_addr     <= 26'h0000000;
         card_enable_low_byte_n  <= 1'b1;
         card_enable_high_byte_n <= 1'b1;
         read_strobe_n      <= 1'b1;
         write_strobe_pin_n <= 1'b1;
         io_cycle     <= 1'b0;
         bus_width16  <= 1'b0;
         bus_busy     <= 1'b0;
      end
      else
      begin
         timer_load <= 1'b0;
         req_done   <= 1'b0;
         case (state)
            `ST_IDLE:
            begin
               if (release_ok)
               begin
                  bus_grant_n <= 1'b0;
                  bus_busy    <= 1'b0;
                  state       <= `ST_RELEASED;
               end
               // Done pulse blocks a rerun of the request still held
               else if (req_valid && !req_done && req_card && (req_low32 || req_io))
               begin
                  cur_area     <= req_area;
                  cur_io       <= req_io;
                  cur_write    <= req_write;
                  io_cycle     <= req_io;
                  bus_width16  <= (req_width == 2'h2);
                  bus_addr     <= req_addr[25:0];
                  fill_active  <= req_fill;
                  burst_left   <= (!req_write && !req_io && req_burst != 2'h0) ?
                                  {1'b0, req_burst} : 3'h0;
                  bus_busy     <= 1'b1;
                  if (need_gap && gap_left != 2'h0)
                  begin
                     timer_count <= {{(TW-2){1'b0}}, gap_left};
                     timer_load  <= 1'b1;
                     state       <= `ST_GAP;
                  end
                  else
                  begin
                     timer_count <= {{(TW-2){1'b0}}, req_setup};
                     timer_load  <= 1'b1;
                     state       <= `ST_SETUP;
                  end
               end
               else if (empty_cnt != 2'h3)
                  empty_cnt <= empty_cnt + 2'h1;
            end
            `ST_GAP:
            begin
               if (timer_done)
               begin
                  timer_count <= {{(TW-2){1'b0}}, setup_cyc};
                  timer_load  <= 1'b1;
                  state       <= `ST_SETUP;
               end
            end
            `ST_SETUP:
            begin
               card_enable_low_byte_n  <= 1'b0;
               card_enable_high_byte_n <= !(bus_width16 && req_word && !do_split);
               if (timer_done && !timer_load)
               begin
                  read_strobe_n      <= cur_write;
                  write_strobe_pin_n <= !cur_write;
                  timer_count <= {{(TW-3){1'b0}}, sw_wait};
                  timer_load  <= 1'b1;
                  state       <= `ST_STROBE;
               end
            end
            `ST_STROBE:
            begin
               if (timer_done && !timer_load && wait_n)
               begin
                  if (burst_left != 3'h0)
                  begin
                     bus_addr    <= bus_addr + 26'h0000002;
                     burst_left  <= burst_left - 3'h1;
                     timer_count <= {{(TW-3){1'b0}}, sw_wait};
                     timer_load  <= 1'b1;
                  end
                  else
                  begin
                     read_strobe_n      <= 1'b1;
                     write_strobe_pin_n <= 1'b1;
                     timer_count <= {{(TW-2){1'b0}}, hold_cyc};
                     timer_load  <= 1'b1;
                     state       <= `ST_HOLD;
                  end
               end
            end
            `ST_HOLD:
            begin
               if (timer_done && !timer_load)
               begin
                  card_enable_low_byte_n  <= 1'b1;
                  card_enable_high_byte_n <= 1'b1;
                  if (do_split)
                  begin
                     split_second <= 1'b1;
                     bus_addr     <= bus_addr + 26'h0000001;
                     timer_count  <= {{(TW-2){1'b0}}, setup_cyc};
                     timer_load   <= 1'b1;
                     state        <= `ST_SETUP;
                  end
                  else
                  begin
                     split_second <= 1'b0;
                     fill_active  <= 1'b0;
                     prev_area    <= cur_area;
                     prev_read    <= !cur_write;
                     prev_valid   <= 1'b1;
                     empty_cnt    <= 2'h0;
                     arb_gap      <= 1'b0;
                     req_done     <= 1'b1;
                     bus_busy     <= 1'b0;
                     state        <= `ST_IDLE;
                  end
               end
            end
            `ST_RELEASED:
            begin
               if (release_req_n)
               begin
                  bus_grant_n <= 1'b1;
                  arb_gap     <= 1'b1;
                  state       <= `ST_IDLE;
               end
            end
            default:
               state <= `ST_IDLE;
         endcase
      end
   end
endmodule

/* tb/card_bus_chk.sv */
// Port assertions for the card bus controller
`timescale 1ns/1ps
module card_bus_chk
(
   input wire        clk,
   input wire        rst_n,
   input wire [28:0] req_addr,
   input wire        req_write,
   input wire [2:0]  req_area,
   input wire        req_done,
   input wire        bus_release_request_n,
   input wire        refresh_pending,
   input wire        refresh_start,
   input wire [3:0]  irq_level,
   input wire [3:0]  interrupt_mask_field,
   input wire        bus_grant_n,
   input wire        bus_reclaim_request_n,
   input wire        card_enable_low_byte_n,
   input wire        card_enable_high_byte_n,
   input wire        read_strobe_n,
   input wire        write_strobe_pin_n,
   input wire        io_cycle,
   input wire        bus_width16,
   input wire        bus_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire ce_on = !card_enable_low_byte_n || !card_enable_high_byte_n;
   reg  want_q;
   always @(posedge clk)
   begin
      want_q <= (refresh_pending && !refresh_start) || (irq_level > interrupt_mask_field);
   end
   a_reclaim_cause: assert property ($past(rst_n) |-> bus_reclaim_request_n == !want_q)
      else $error("reclaim output does not follow refresh or interrupt state");
   a_grant_quiet: assert property (!bus_grant_n |-> !bus_busy && !ce_on && read_strobe_n)
      else $error("bus driven while granted");
   a_grant_cause: assert property ($fell(bus_grant_n) |-> !$past(bus_release_request_n, 2)
      && !$past(bus_busy))
      else $error("grant without request or during access");
   a_grant_drop: assert property (bus_release_request_n [*6] |-> bus_grant_n)
      else $error("grant held after request negated");
   a_io_window: assert property (io_cycle && ce_on |-> req_area == 3'h6
      && req_addr[28:25] == 4'hd)
      else $error("io cycle outside area 6 window");
   a_write_dir: assert property (!write_strobe_pin_n |-> req_write && read_strobe_n)
      else $error("write strobe on a read");
   a_read_dir: assert property (!read_strobe_n |-> !req_write)
      else $error("read strobe on a write");
   a_setup_order: assert property ($fell(read_strobe_n) || $fell(write_strobe_pin_n)
      |-> $past(ce_on))
      else $error("strobe without card enable set-up");
   a_wide_enable: assert property (!card_enable_high_byte_n |-> bus_width16)
      else $error("high byte enable on narrow bus");
   a_done_pulse: assert property (req_done |=> !req_done)
      else $error("done longer than one cycle");
endmodule
bind card_bus_ctrl card_bus_chk chk (.clk(clk), .rst_n(rst_n), .req_addr(req_addr),
   .req_write(req_write), .req_area(req_area), .req_done(req_done),
   .bus_release_request_n(bus_release_request_n), .refresh_pending(refresh_pending),
   .refresh_start(refresh_start), .irq_level(irq_level),
   .interrupt_mask_field(interrupt_mask_field), .bus_grant_n(bus_grant_n),
   .bus_reclaim_request_n(bus_reclaim_request_n),
   .card_enable_low_byte_n(card_enable_low_byte_n),
   .card_enable_high_byte_n(card_enable_high_byte_n), .read_strobe_n(read_strobe_n),
   .write_strobe_pin_n(write_strobe_pin_n), .io_cycle(io_cycle),
   .bus_width16(bus_width16), .bus_busy(bus_busy));

/* tb/card_partner.sv */
// Card and external bus master model on the far side
`timescale 1ns/1ps
module card_partner
(
   input  wire       clk,
   input  wire       strobe_n,
   input  wire [3:0] stretch,
   input  wire       narrow,
   input  wire       want_bus,
   input  wire       bus_reclaim_request_n,
   output reg        wait_pin_n,
   output wire       io_port_wide_sense_n,
   output reg        bus_release_request_n
);
   reg [3:0] cnt;
   reg       strobe_q;
   initial
   begin
      cnt = 4'h0;
      strobe_q = 1'b1;
      wait_pin_n = 1'b1;
      bus_release_request_n = 1'b1;
   end
   // Port width decode held static, not per address
   assign io_port_wide_sense_n = narrow;
   always @(posedge clk)
   begin
      strobe_q <= strobe_n;
      if (strobe_q && !strobe_n)
         cnt <= stretch;
      else if (cnt != 4'h0)
         cnt <= cnt - 4'h1;
      wait_pin_n <= (cnt == 4'h0);
      // Gives the bus back as soon as reclaim is seen
      bus_release_request_n <= !(want_bus && bus_reclaim_request_n);
   end
endmodule

/* tb/tb_top.sv */
// Self-checking testbench for the card bus controller
`timescale 1ns/1ps
module tb_top;
   reg         clk, rst_n, reg_write, reg_read, req_valid, req_write, req_word, req_fill;
   reg  [2:0]  reg_addr, req_area;
   reg  [31:0] reg_wdata;
   reg  [28:0] req_addr;
   reg         refresh_pending, refresh_start, narrow, want_bus;
   reg  [3:0]  irq_level, interrupt_mask_field, stretch;
   wire [31:0] reg_rdata;
   wire [25:0] bus_addr;
   wire        req_done, wait_pin_n, sense_n, brq_n, bus_grant_n, reclaim_n, ce_lo_n, ce_hi_n;
   wire        read_strobe_n, write_strobe_pin_n, io_cycle, bus_width16, bus_busy;
   integer     errors, tests_run, lat, np, io_seen, a, b, c, i;

   card_bus_ctrl uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write), .req_word(req_word),
      .req_fill(req_fill), .req_area(req_area), .req_done(req_done), .wait_pin_n(wait_pin_n),
      .io_port_wide_sense_n(sense_n), .bus_release_request_n(brq_n),
      .refresh_pending(refresh_pending), .refresh_start(refresh_start),
      .irq_level(irq_level), .interrupt_mask_field(interrupt_mask_field),
      .bus_grant_n(bus_grant_n), .bus_reclaim_request_n(reclaim_n), .bus_addr(bus_addr),
      .card_enable_low_byte_n(ce_lo_n), .card_enable_high_byte_n(ce_hi_n),
      .read_strobe_n(read_strobe_n), .write_strobe_pin_n(write_strobe_pin_n),
      .io_cycle(io_cycle), .bus_width16(bus_width16), .bus_busy(bus_busy));
   card_partner far (.clk(clk), .strobe_n(read_strobe_n & write_strobe_pin_n),
      .stretch(stretch), .narrow(narrow), .want_bus(want_bus),
      .bus_reclaim_request_n(reclaim_n), .wait_pin_n(wait_pin_n),
      .io_port_wide_sense_n(sense_n), .bus_release_request_n(brq_n));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task summarize;
   begin
      $display("Counts: %0d checks, %0d mismatches", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask

   task check(input [31:0] seen, input [31:0] exp);
   begin
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         errors = errors + 1;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask

   task wr(input [2:0] ad, input [31:0] d);
   begin
      reg_addr <= ad;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      @(posedge clk);
   end
   endtask

   task rd(input [2:0] ad, input [31:0] exp);
   begin
      reg_addr <= ad;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(posedge clk);
      check(reg_rdata, exp);
   end
   endtask

   // Waits on done; a lost access ends the run unless none was expected
   task acc(input [2:0] ar, input [28:0] ad, input w, input wd, input ex);
      reg p, s;
   begin
      @(posedge clk);
      lat = -1; np = 0; io_seen = 0; p = 1'b1;
      req_valid <= 1'b1; req_area <= ar; req_addr <= ad; req_write <= w; req_word <= wd;
      for (i = 0; i < 200 && lat < 0; i = i + 1)
      begin
         @(posedge clk);
         s = read_strobe_n & write_strobe_pin_n;
         if (p && !s)
            np = np + 1;
         p = s;
         if (io_cycle === 1'b1 && ce_lo_n === 1'b0)
            io_seen = 1;
         if (req_done === 1'b1)
            lat = i;
      end
      req_valid <= 1'b0;
      if (ex && lat < 0)
      begin
         check(0, 1);
         summarize;
      end
   end
   endtask

   task grant_is(input v);
   begin
      for (i = 0; i < 30 && bus_grant_n !== v; i = i + 1)
         @(posedge clk);
      check(bus_grant_n, v);
      if (i == 30)
         summarize;
   end
   endtask

   task t_regs;
   begin
      check({bus_grant_n, reclaim_n, read_strobe_n, write_strobe_pin_n, ce_lo_n}, 5'h1f);
      wr(3'h0, 32'h0000000c);
      rd(3'h0, 32'h0000000c);
      wr(3'h7, 32'hffffffff);
      rd(3'h7, 32'h00000000);
      $display("Test registers done");
   end
   endtask

   task t_areas;
   begin
      wr(3'h0, 32'h00000000);
      acc(3'h5, 29'h14000000, 1'b0, 1'b0, 1'b0);
      check(lat, -1);
      wr(3'h0, 32'h0000000c);
      acc(3'h5, 29'h15000010, 1'b0, 1'b0, 1'b1);
      check({np[3:0], io_seen[3:0]}, 8'h10);
      check(bus_addr, 32'h01000010);
      acc(3'h5, 29'h16000000, 1'b0, 1'b0, 1'b0);
      check(lat, -1);
      acc(3'h6, 29'h1a000000, 1'b0, 1'b0, 1'b1);
      check(io_seen, 1);
      acc(3'h6, 29'h18000000, 1'b0, 1'b0, 1'b1);
      check(io_seen, 0);
      $display("Test areas done");
   end
   endtask

   task t_sizing;
   begin
      wr(3'h1, 32'h00002000);
      wr(3'h6, 32'h00000001);
      narrow <= 1'b1;
      acc(3'h6, 29'h1a000000, 1'b0, 1'b1, 1'b1);
      check(np, 2);
      check(bus_width16, 1);
      narrow <= 1'b0;
      acc(3'h6, 29'h1a000000, 1'b0, 1'b1, 1'b1);
      check(np, 1);
      wr(3'h6, 32'h00000000);
      narrow <= 1'b1;
      acc(3'h6, 29'h1a000000, 1'b0, 1'b1, 1'b1);
      check(np, 1);
      narrow <= 1'b0;
      $display("Test sizing done");
   end
   endtask

   task t_idle;
   begin
      wr(3'h2, 32'h00000000);
      acc(3'h5, 29'h14000000, 1'b0, 1'b0, 1'b1);
      acc(3'h5, 29'h14000000, 1'b0, 1'b0, 1'b1);
      a = lat;
      wr(3'h2, 32'h00003c00);
      acc(3'h5, 29'h14000000, 1'b0, 1'b0, 1'b1);
      check(lat, a);
      acc(3'h5, 29'h14000000, 1'b1, 1'b0, 1'b1);
      b = lat;
      acc(3'h5, 29'h14000000, 1'b1, 1'b0, 1'b1);
      check(b > lat, 1);
      acc(3'h6, 29'h18000000, 1'b0, 1'b0, 1'b1);
      b = lat;
      acc(3'h6, 29'h18000000, 1'b0, 1'b0, 1'b1);
      c = lat;
      check(b > c && b - c < 4, 1);
      wr(3'h2, 32'h00000000);
      acc(3'h5, 29'h14000000, 1'b0, 1'b0, 1'b1);
      acc(3'h6, 29'h18000000, 1'b0, 1'b0, 1'b1);
      check(lat, c);
      wr(3'h2, 32'h00003c00);
      acc(3'h5, 29'h14000000, 1'b0, 1'b0, 1'b1);
      repeat (10) @(posedge clk);
      acc(3'h6, 29'h18000000, 1'b0, 1'b0, 1'b1);
      check(lat, c);
      wr(3'h2, 32'h00000000);
      $display("Test idle insertion done");
   end
   endtask

   task t_waits;
   begin
      wr(3'h3, 32'h00000000);
      acc(3'h5, 29'h14000000, 1'b0, 1'b0, 1'b1);
      a = lat;
      wr(3'h3, 32'h00010000);
      acc(3'h5, 29'h14000000, 1'b0, 1'b0, 1'b1);
      check(lat - a, 2);
      wr(3'h3, 32'h00038000);
      acc(3'h5, 29'h14000000, 1'b0, 1'b0, 1'b1);
      a = lat;
      stretch <= 4'h8;
      acc(3'h5, 29'h14000000, 1'b0, 1'b0, 1'b1);
      check(lat > a, 1);
      stretch <= 4'h0;
      wr(3'h3, 32'h00000000);
      $display("Test waits done");
   end
   endtask

   task t_burst_arb;
   begin
      acc(3'h5, 29'h14000000, 1'b0, 1'b0, 1'b1);
      a = lat;
      wr(3'h0, 32'h0000004c);
      acc(3'h5, 29'h14000000, 1'b1, 1'b0, 1'b1);
      check(np, 1);
      req_fill <= 1'b1;
      fork
         acc(3'h5, 29'h14000000, 1'b0, 1'b0, 1'b1);
         begin
            repeat (3) @(posedge clk);
            want_bus <= 1'b1;
         end
      join
      check(lat > a, 1);
      check(bus_addr, 32'h00000002);
      req_fill <= 1'b0;
      grant_is(1'b0);
      check(bus_busy, 0);
      refresh_pending <= 1'b1;
      grant_is(1'b1);
      check(reclaim_n, 0);
      refresh_start <= 1'b1;
      repeat (2) @(posedge clk);
      check(reclaim_n, 1);
      refresh_pending <= 1'b0;
      refresh_start <= 1'b0;
      irq_level <= 4'h5;
      repeat (2) @(posedge clk);
      check(reclaim_n, 0);
      interrupt_mask_field <= 4'h5;
      repeat (2) @(posedge clk);
      check(reclaim_n, 1);
      want_bus <= 1'b0;
      $display("Test burst and arbitration done");
   end
   endtask

   initial
   begin
      errors = 0; tests_run = 0;
      rst_n = 1'b0; reg_write = 1'b0; reg_read = 1'b0; reg_addr = 3'h0; reg_wdata = 32'h0;
      req_valid = 1'b0; req_write = 1'b0; req_word = 1'b0; req_fill = 1'b0;
      req_area = 3'h7; req_addr = 29'h0; refresh_pending = 1'b0; refresh_start = 1'b0;
      irq_level = 4'h0; interrupt_mask_field = 4'h0; narrow = 1'b0; want_bus = 1'b0;
      stretch = 4'h0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      t_regs;
      t_areas;
      t_sizing;
      t_idle;
      t_waits;
      t_burst_arb;
      summarize;
   end
endmodule
